/* File: design/tssr_pin_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module tssr_pin_sync
  import tssr_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_pin,
  output logic o_level
);
  tssr_sync_t s_r;
  tssr_sync_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.f1 = i_pin;
    s_nxt.f2 = s_r.f1;
    s_nxt.f3 = s_r.f2;
    // a change only counts once two late stages agree
    if (s_r.f2 == s_r.f3) begin
      s_nxt.lvl = s_r.f3;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '{f1: RST_VAL, f2: RST_VAL, f3: RST_VAL, lvl: RST_VAL};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_level = s_r.lvl;

  property p_sync_agree;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (s_r.f2 == s_r.f3) |=> (s_r.lvl == $past(s_r.f3));
  endproperty
  a_sync_agree: assert property (p_sync_agree) else $error("sync level missed agreed value");
endmodule : tssr_pin_sync

/* File: design/tssr_pkg.sv */
// constants and shared types of the thermal sensor bus register block
package tssr_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int CONV_PERIOD_MS = 125;
  localparam int CONV_CYC = CLK_HZ / 1000 * CONV_PERIOD_MS;
  localparam int TO_MAX_MS = 35;
  localparam int TO_CYC = CLK_HZ / 1000 * TO_MAX_MS;
  localparam int CNT_W = 25;

  localparam logic [7:0] PTR_CAP = 8'h00;
  localparam logic [7:0] PTR_CFG = 8'h01;
  localparam logic [7:0] PTR_UPPER = 8'h02;
  localparam logic [7:0] PTR_LOWER = 8'h03;
  localparam logic [7:0] PTR_CRIT = 8'h04;
  localparam logic [7:0] PTR_TEMP = 8'h05;
  localparam logic [7:0] PTR_OPTS = 8'h22;
  localparam logic [7:0] PTR_RST = 8'h00;

  localparam logic [15:0] CAP_RST = 16'h0017;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] LIM_RST = 16'h0000;
  localparam logic [15:0] OPTS_RST = 16'h0000;
  localparam logic [15:0] TEMP_RST = 16'h0000;

  localparam int CFG_MODE_B = 0;
  localparam int CFG_POL_B = 1;
  localparam int CFG_EN_B = 3;
  localparam int CFG_CEVT_B = 5;
  localparam int CFG_SHDN_B = 8;
  localparam int OPTS_TO_DIS_B = 7;

  localparam logic [6:0] ARA_ADDR = 7'h0c;
  localparam logic [1:0] BIDX_ADDR = 2'h0;
  localparam logic [1:0] BIDX_PTR = 2'h1;
  localparam logic [1:0] BIDX_DHI = 2'h2;
  localparam logic [1:0] BIDX_DLO = 2'h3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_MACK} tssr_st_t;

  typedef struct packed {
    logic f1;
    logic f2;
    logic f3;
    logic lvl;
  } tssr_sync_t;

  typedef struct packed {
    tssr_st_t st;
    logic [3:0] bcnt;
    logic [1:0] bidx;
    logic [7:0] sh;
    logic rw;
    logic ara;
    logic mack;
    logic sda_oe;
    logic [7:0] ptr;
    logic [7:0] wr_hi;
    logic [15:0] tx;
    logic [15:0] cfg;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] crit;
    logic [15:0] opts;
    logic [15:0] temp;
    logic [CNT_W-1:0] conv_cnt;
    logic [CNT_W-1:0] to_cnt;
    logic evt;
    logic cond_d;
    logic ev_oe;
    logic scl_d;
    logic sda_d;
  } tssr_state_t;
endpackage : tssr_pkg

/* File: design/tssr_top.sv */
// bus slave, register file, conversion timing and alert handling of the sensor
`timescale 1ns/1ps
module tssr_top
  import tssr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h18,
  parameter int CONV_CYC_P = CONV_CYC,
  parameter int TO_CYC_P = TO_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic [15:0] i_adc_temp,
  input wire logic i_evt_cond,
  output logic o_event_o,
  output logic o_event_oe
);
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC_P - 1);
  localparam logic [CNT_W-1:0] TO_LAST = CNT_W'(TO_CYC_P - 1);

  logic [1:0] rst_q;
  logic rst_n;
  logic scl;
  logic sda;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic ara_ok;
  logic wr_en;
  logic evt_clr;
  logic ld_tx;
  logic [15:0] rd_word;
  logic [15:0] wdata;
  tssr_state_t s_r;
  tssr_state_t s_nxt;
  // reset released only after two clean edges
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];
  tssr_pin_sync #(.RST_VAL(1'b1)) u_scl_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .i_pin(i_scl),
    .o_level(scl)
  );
  tssr_pin_sync #(.RST_VAL(1'b1)) u_sda_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .i_pin(i_sda),
    .o_level(sda)
  );
  assign rise = scl & ~s_r.scl_d;
  assign fall = ~scl & s_r.scl_d;
  assign start = scl & s_r.scl_d & s_r.sda_d & ~sda;
  assign stop = scl & s_r.scl_d & ~s_r.sda_d & sda;
  assign wdata = {s_r.wr_hi, s_r.sh};
  assign ara_ok = s_r.cfg[CFG_MODE_B] & ~s_r.cfg[CFG_POL_B] & s_r.cfg[CFG_EN_B] & s_r.evt;
  always_comb begin
    rd_word = 16'h0000;
    if (s_r.ara) begin
      rd_word = {DEV_ADDR, 1'b1, 8'h00};
    end else begin
      unique case (s_r.ptr)
        PTR_CAP: rd_word = CAP_RST;
        PTR_CFG: rd_word = s_r.cfg;
        PTR_UPPER: rd_word = s_r.upper;
        PTR_LOWER: rd_word = s_r.lower;
        PTR_CRIT: rd_word = s_r.crit;
        PTR_TEMP: rd_word = s_r.temp;
        PTR_OPTS: rd_word = s_r.opts;
        default: rd_word = 16'h0000;
      endcase
    end
  end

  always_comb begin
    s_nxt = s_r;
    wr_en = 1'b0;
    evt_clr = 1'b0;
    ld_tx = 1'b0;
    s_nxt.scl_d = scl;
    s_nxt.sda_d = sda;

    if (start) begin
      s_nxt.st = S_RX;
      s_nxt.bcnt = 4'h0;
      s_nxt.bidx = BIDX_ADDR;
      s_nxt.sda_oe = 1'b0;
      s_nxt.ara = 1'b0;
    end else if (stop) begin
      s_nxt.st = S_IDLE;
      s_nxt.sda_oe = 1'b0;
    end else begin
      unique case (s_r.st)
        S_IDLE: begin
        end
        S_RX: begin
          if (rise) begin
            s_nxt.sh = {s_r.sh[6:0], sda};
            s_nxt.bcnt = s_r.bcnt + 4'h1;
          end else if (fall && s_r.bcnt == BITS_PER_BYTE) begin
            s_nxt.bcnt = 4'h0;
            s_nxt.st = S_ACK;
            s_nxt.sda_oe = 1'b1;
            unique case (s_r.bidx)
              BIDX_ADDR: begin
                s_nxt.rw = s_r.sh[0];
                if (s_r.sh[7:1] == DEV_ADDR) begin
                  s_nxt.ara = 1'b0;
                end else if (s_r.sh[7:1] == ARA_ADDR && s_r.sh[0] && ara_ok) begin
                  s_nxt.ara = 1'b1;
                end else begin
                  s_nxt.st = S_IDLE;
                  s_nxt.sda_oe = 1'b0;
                end
              end
              BIDX_PTR: s_nxt.ptr = s_r.sh;
              BIDX_DHI: s_nxt.wr_hi = s_r.sh;
              BIDX_DLO: wr_en = 1'b1;
            endcase
          end
        end
        S_ACK: begin
          if (fall) begin
            s_nxt.bcnt = 4'h0;
            if (s_r.bidx == BIDX_ADDR && s_r.rw) begin
              ld_tx = 1'b1;
              s_nxt.tx = rd_word;
              s_nxt.sda_oe = ~rd_word[15];
              s_nxt.st = S_TX;
            end else begin
              s_nxt.sda_oe = 1'b0;
              s_nxt.st = S_RX;
              s_nxt.bidx = (s_r.bidx == BIDX_DLO) ? BIDX_DHI : s_r.bidx + 2'h1;
            end
          end
        end
        S_TX: begin
          if (rise) begin
            s_nxt.bcnt = s_r.bcnt + 4'h1;
            if (s_r.ara && !s_r.sda_oe && !sda) begin
              s_nxt.st = S_IDLE;
            end
          end else if (fall) begin
            s_nxt.tx = {s_r.tx[14:0], 1'b0};
            if (s_r.bcnt == BITS_PER_BYTE) begin
              s_nxt.st = S_MACK;
              s_nxt.sda_oe = 1'b0;
              s_nxt.bcnt = 4'h0;
            end else begin
              s_nxt.sda_oe = ~s_r.tx[14];
            end
          end
        end
        S_MACK: begin
          if (rise) begin
            s_nxt.mack = ~sda;
          end else if (fall) begin
            if (s_r.ara) begin
              evt_clr = 1'b1;
              s_nxt.st = S_IDLE;
            end else if (s_r.mack) begin
              s_nxt.st = S_TX;
              s_nxt.sda_oe = ~s_r.tx[15];
            end else begin
              s_nxt.st = S_IDLE;
            end
          end
        end
      endcase
    end

    // a full data pair commits the write
    if (wr_en) begin
      unique case (s_r.ptr)
        PTR_CFG: begin
          s_nxt.cfg = wdata & ~(16'h0001 << CFG_CEVT_B);
          evt_clr = wdata[CFG_CEVT_B];
        end
        PTR_UPPER: s_nxt.upper = wdata;
        PTR_LOWER: s_nxt.lower = wdata;
        PTR_CRIT: s_nxt.crit = wdata;
        PTR_OPTS: s_nxt.opts = wdata;
        default: begin
        end
      endcase
    end

    if (s_r.cfg[CFG_SHDN_B]) begin
      s_nxt.conv_cnt = '0;
    end else if (s_r.conv_cnt == CONV_LAST) begin
      s_nxt.conv_cnt = '0;
      s_nxt.temp = i_adc_temp;
    end else begin
      s_nxt.conv_cnt = s_r.conv_cnt + CNT_W'(1);
    end

    // interrupt mode is sticky; a new event beats a clear in the same cycle
    s_nxt.cond_d = i_evt_cond;
    if (s_r.cfg[CFG_MODE_B]) begin
      if (i_evt_cond && !s_r.cond_d) begin
        s_nxt.evt = 1'b1;
      end else if (evt_clr) begin
        s_nxt.evt = 1'b0;
      end
    end else begin
      s_nxt.evt = i_evt_cond;
    end
    s_nxt.ev_oe = s_r.cfg[CFG_EN_B] & (s_r.evt ^ s_r.cfg[CFG_POL_B]);

    if (s_r.opts[OPTS_TO_DIS_B] || s_r.cfg[CFG_SHDN_B] || scl || s_r.st == S_IDLE) begin
      s_nxt.to_cnt = '0;
    end else if (s_r.to_cnt == TO_LAST) begin
      s_nxt.to_cnt = '0;
      s_nxt.st = S_IDLE;
      s_nxt.sda_oe = 1'b0;
    end else begin
      s_nxt.to_cnt = s_r.to_cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{st: S_IDLE, ptr: PTR_RST, cfg: CFG_RST, upper: LIM_RST, lower: LIM_RST,
               crit: LIM_RST, opts: OPTS_RST, temp: TEMP_RST, scl_d: 1'b1, sda_d: 1'b1,
               default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_sda_o = 1'b0;
  assign o_sda_oe = s_r.sda_oe;
  assign o_event_o = 1'b0;
  assign o_event_oe = s_r.ev_oe;
  property p_cap_value;
    @(posedge i_clk_sys) disable iff (!rst_n)
      (ld_tx && !s_r.ara && s_r.ptr == PTR_CAP) |=> (s_r.tx == 16'h0017);
  endproperty
  a_cap_value: assert property (p_cap_value) else $error("capability word wrong");
  property p_temp_load;
    @(posedge i_clk_sys) disable iff (!rst_n)
      (ld_tx && !s_r.ara && s_r.ptr == PTR_TEMP) |=> (s_r.tx == $past(s_r.temp));
  endproperty
  a_temp_load: assert property (p_temp_load) else $error("temperature read not latest");
  property p_tx_frozen;
    @(posedge i_clk_sys) disable iff (!rst_n)
      (s_r.st == S_TX && $past(s_r.st) == S_TX) |->
        (s_r.tx == $past(s_r.tx) || s_r.tx == {$past(s_r.tx[14:0]), 1'b0});
  endproperty
  a_tx_frozen: assert property (p_tx_frozen) else $error("shift word changed mid read");
  property p_conv_update;
    @(posedge i_clk_sys) disable iff (!rst_n)
      (s_r.conv_cnt == CONV_LAST && !s_r.cfg[CFG_SHDN_B]) |=>
        (s_r.temp == $past(i_adc_temp) && s_r.conv_cnt == '0);
  endproperty
  a_conv_update: assert property (p_conv_update) else $error("conversion end missed");
  property p_timeout_idle;
    @(posedge i_clk_sys) disable iff (!rst_n)
      (s_r.to_cnt == TO_LAST && !scl && !s_r.opts[OPTS_TO_DIS_B] && !s_r.cfg[CFG_SHDN_B])
        |=> (s_r.st == S_IDLE && !s_r.sda_oe);
  endproperty
  a_timeout_idle: assert property (p_timeout_idle) else $error("time-out did not idle");
  property p_to_disabled;
    @(posedge i_clk_sys) disable iff (!rst_n)
      s_r.opts[OPTS_TO_DIS_B] |=> (s_r.to_cnt == '0);
  endproperty
  a_to_disabled: assert property (p_to_disabled) else $error("time-out ran while off");
  property p_shdn_no_to;
    @(posedge i_clk_sys) disable iff (!rst_n)
      s_r.cfg[CFG_SHDN_B] |=> (s_r.to_cnt == '0 && s_r.conv_cnt == '0);
  endproperty
  a_shdn_no_to: assert property (p_shdn_no_to) else $error("timer ran in shutdown");
  property p_ara_gate;
    @(posedge i_clk_sys) disable iff (!rst_n)
      $rose(s_r.ara) |-> $past(ara_ok);
  endproperty
  a_ara_gate: assert property (p_ara_gate) else $error("alert response without gate");
  property p_ara_lost;
    @(posedge i_clk_sys) disable iff (!rst_n)
      (s_r.st == S_TX && s_r.ara && rise && !sda && !s_r.sda_oe && !start && !stop)
        |=> (s_r.st == S_IDLE && !s_r.sda_oe);
  endproperty
  a_ara_lost: assert property (p_ara_lost) else $error("arbitration loss ignored");
  property p_alert_off;
    @(posedge i_clk_sys) disable iff (!rst_n)
      !s_r.cfg[CFG_EN_B] |=> !s_r.ev_oe;
  endproperty
  a_alert_off: assert property (p_alert_off) else $error("alert driven while disabled");
endmodule : tssr_top

/* File: testbench/testbench.sv */
// self-checking bench of the sensor bus register block
`timescale 1ns/1ps
module testbench
  import tssr_pkg::*;
;
  logic clk, nrst, ext_low, evt, sda_oe, sda_o, ev_o, ev_oe, scl, sda_h, sda_w;
  logic [15:0] adc;
  logic [7:0] regs [6] = '{PTR_CAP, PTR_CFG, PTR_UPPER, PTR_LOWER, PTR_CRIT, PTR_OPTS};
  int err_total = 0;
  int check_count = 0;
  // pulled-up wire; a second alerting slave may pull it low
  assign sda_w = sda_h & ~(sda_oe & ~sda_o) & ~ext_low;
  tssr_host host_u (
    .i_clk_sys(clk),
    .i_sda_w(sda_w),
    .o_scl(scl),
    .o_sda(sda_h)
  );
  tssr_top #(.CONV_CYC_P(200), .TO_CYC_P(400)) dut_u (
    .i_clk_sys(clk),
    .i_nrst(nrst),
    .i_scl(scl),
    .i_sda(sda_w),
    .o_sda_o(sda_o),
    .o_sda_oe(sda_oe),
    .i_adc_temp(adc),
    .i_evt_cond(evt),
    .o_event_o(ev_o),
    .o_event_oe(ev_oe)
  );
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  task automatic t_reset();
    logic [15:0] v;
    logic ok;
    chk({14'h0, sda_oe, ev_oe}, 16'h0000);
    chk({14'h0, sda_o, ev_o}, 16'h0000);
    host_u.rd_reg(1'b0, 8'h00, v, ok);
    chk(v, CAP_RST);
    for (int i = 1; i < 6; i++) begin
      host_u.rd_reg(1'b1, regs[i], v, ok);
      chk(v | {15'h0, ~ok}, 16'h0000);
    end
    host_u.wr_reg(PTR_CAP, 16'hffff, ok);
    host_u.rd_reg(1'b1, PTR_CAP, v, ok);
    chk(v, CAP_RST);
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs();
    logic [15:0] vals [3] = '{16'h0550, 16'h1f40, 16'h05f0};
    logic [15:0] v;
    logic ok;
    for (int i = 0; i < 3; i++) begin
      host_u.wr_reg(regs[i+2], vals[i], ok);
      chk({15'h0, ok}, 16'h0001);
    end
    for (int i = 0; i < 3; i++) begin
      host_u.rd_reg(1'b1, regs[i+2], v, ok);
      chk(v, vals[i]);
    end
    // pointer still at the last one set
    host_u.rd_reg(1'b0, 8'h00, v, ok);
    chk(v, vals[2]);
    $display("test regs done");
  endtask : t_regs
  task automatic t_temp();
    logic [15:0] v;
    logic ok;
    adc <= 16'h1111;
    host_u.rd_reg(1'b1, PTR_TEMP, v, ok);
    chk(v, 16'h1111);
    host_u.start();
    host_u.wbyte(8'h31, ok);
    // conversions finish while this word is shifted out
    adc <= 16'h2222;
    host_u.rd_word(v);
    host_u.stop();
    chk(v, 16'h1111);
    host_u.rd_reg(1'b0, 8'h00, v, ok);
    chk(v, 16'h2222);
    $display("test temp done");
  endtask : t_temp
  task automatic t_tout();
    logic [15:0] v;
    logic ok;
    for (int i = 0; i < 3; i++) begin
      host_u.wr_reg(PTR_OPTS, (i == 1) ? 16'h0080 : 16'h0000, ok);
      host_u.wr_reg(PTR_CFG, (i == 2) ? 16'h0100 : 16'h0000, ok);
      host_u.rd_reg(1'b1, PTR_CAP, v, ok);
      host_u.start();
      host_u.wbyte(8'h31, ok);
      // scl held low past the 400-cycle window
      host_u.tick(450);
      chk({15'h0, sda_oe}, {15'h0, i != 0});
      if (i != 0) begin
        host_u.rd_word(v);
        chk(v, CAP_RST);
      end
      host_u.stop();
    end
    host_u.wr_reg(PTR_CFG, 16'h0000, ok);
    $display("test timeout done");
  endtask : t_tout
  task automatic ara(input logic lose, output logic [7:0] d, output logic ok);
    host_u.start();
    host_u.wbyte({ARA_ADDR, 1'b1}, ok);
    ext_low <= lose;
    host_u.rbyte(1'b1, d);
    ext_low <= 1'b0;
    host_u.stop();
  endtask : ara
  task automatic pulse();
    evt <= 1'b1;
    host_u.tick(2);
    evt <= 1'b0;
    host_u.tick(5);
  endtask : pulse
  task automatic t_alert();
    logic [7:0] d;
    logic [15:0] v;
    logic ok;
    host_u.wr_reg(PTR_CFG, 16'h0008, ok);
    evt <= 1'b1;
    host_u.tick(5);
    chk({15'h0, ev_oe}, 16'h0001);
    ara(1'b0, d, ok);
    chk({15'h0, ok}, 16'h0000);
    evt <= 1'b0;
    host_u.tick(5);
    chk({15'h0, ev_oe}, 16'h0000);
    host_u.wr_reg(PTR_CFG, 16'h0009, ok);
    pulse();
    ara(1'b1, d, ok);
    chk({14'h0, ok, ev_oe}, 16'h0003);
    ara(1'b0, d, ok);
    host_u.tick(5);
    chk({7'h0, d, ok}, {7'h0, 8'h31, 1'b1});
    chk({15'h0, ev_oe}, 16'h0000);
    // clear-event bit drops a pending alert and always reads back as zero
    pulse();
    chk({15'h0, ev_oe}, 16'h0001);
    host_u.wr_reg(PTR_CFG, 16'h0029, ok);
    chk({15'h0, ev_oe}, 16'h0000);
    host_u.rd_reg(1'b1, PTR_CFG, v, ok);
    chk(v, 16'h0009);
    host_u.wr_reg(PTR_CFG, 16'h000b, ok);
    pulse();
    ara(1'b0, d, ok);
    chk({15'h0, ok}, 16'h0000);
    host_u.wr_reg(PTR_CFG, 16'h0000, ok);
    $display("test alert done");
  endtask : t_alert
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // about 41k cycles expected for all tests
  initial begin
    repeat (95000) @(posedge clk);
    err_total++;
    end_sim();
  end
  initial begin
    nrst = 1'b0;
    ext_low = 1'b0;
    evt = 1'b0;
    adc = 16'h0000;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    host_u.tick(10);
    t_reset();
    t_regs();
    t_temp();
    t_tout();
    t_alert();
    end_sim();
  end
endmodule : testbench

/* File: testbench/tssr_host.sv */
// smbus host controller model that drives the sensor's clock and data pins
`timescale 1ns/1ps
module tssr_host #(
  parameter logic [6:0] ADDR = 7'h18
) (
  input wire logic i_clk_sys,
  input wire logic i_sda_w,
  output logic o_scl,
  output logic o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : tick
  // also used as repeated start from a low clock
  task automatic start();
    o_sda <= 1'b1;
    tick(6);
    o_scl <= 1'b1;
    tick(12);
    o_sda <= 1'b0;
    tick(12);
    o_scl <= 1'b0;
    tick(6);
  endtask : start
  // 25 cycles a bit, 125 ns at 200 mhz
  task automatic bit_io(input logic b, output logic r);
    o_sda <= b;
    tick(6);
    o_scl <= 1'b1;
    tick(6);
    r = i_sda_w;
    tick(7);
    o_scl <= 1'b0;
    tick(6);
  endtask : bit_io
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wbyte
  // last high sends nack
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask : rbyte
  task automatic stop();
    o_sda <= 1'b0;
    tick(6);
    o_scl <= 1'b1;
    tick(12);
    o_sda <= 1'b1;
    tick(12);
  endtask : stop
  task automatic rd_word(output logic [15:0] v);
    rbyte(1'b0, v[15:8]);
    rbyte(1'b1, v[7:0]);
  endtask : rd_word
  task automatic wr_reg(input logic [7:0] p, input logic [15:0] v, output logic ok);
    logic a;
    start();
    wbyte({ADDR, 1'b0}, ok);
    wbyte(p, a);
    ok = ok & a;
    wbyte(v[15:8], a);
    ok = ok & a;
    wbyte(v[7:0], a);
    ok = ok & a;
    stop();
  endtask : wr_reg
  // current pointer or pointer then repeated start
  task automatic rd_reg(input logic setp, input logic [7:0] p, output logic [15:0] v,
                        output logic ok);
    logic a;
    ok = 1'b1;
    if (setp) begin
      start();
      wbyte({ADDR, 1'b0}, a);
      wbyte(p, ok);
      ok = ok & a;
    end
    start();
    wbyte({ADDR, 1'b1}, a);
    ok = ok & a;
    rd_word(v);
    stop();
  endtask : rd_reg
endmodule : tssr_host
